//--- src/spw_map.vh
// register map and field constants for the pulse, thermal and wake block
`ifndef SPW_MAP_VH
`define SPW_MAP_VH

// ----------------------------------------------------------------------
// register offsets (7-bit link addresses)
// ----------------------------------------------------------------------
`define SPW_ADDR_PULSE_RATE 7'h1c
`define SPW_ADDR_THERMAL 7'h1d
`define SPW_ADDR_SCRATCH_LO 7'h1e
`define SPW_ADDR_SCRATCH_HI 7'h1f
`define SPW_ADDR_WAKE_CTRL 7'h20
`define SPW_ADDR_QUANTA 7'h21

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPW_RST_PULSE_RATE 2'h0
`define SPW_RST_THERMAL 3'h1
`define SPW_RST_SCRATCH 8'h00
`define SPW_RST_WAKE_CTRL 8'h00
`define SPW_RST_QUANTA 8'ha0

// ----------------------------------------------------------------------
// field positions in the wake control and thermal registers
// ----------------------------------------------------------------------
`define SPW_WC_CAL_BIT 7
`define SPW_WC_TRIM_HI 6
`define SPW_WC_TRIM_LO 5
`define SPW_WC_MASK_BIT 4
`define SPW_WC_VALID_BIT 0
`define SPW_TRIM_UNLOCK 2'h3
`define SPW_THERM_CUTOFF_BIT 2

// ----------------------------------------------------------------------
// link frame and pulse timing
// ----------------------------------------------------------------------
`define SPW_FRAME_BITS 5'h10
`define SPW_ADDR_BITS 5'h08
`define SPW_SYS_CLK_HZ 100000000
`define SPW_RATE0_HZ 100
`define SPW_RATE1_HZ 200
`define SPW_RATE2_HZ 325
`define SPW_RATE3_HZ 400

`endif

//--- src/spw_config_regs.v
// link-accessed pulse rate, thermal, scratch and selective-wake registers
`timescale 1ns/10ps
// Summary of operation
// - pulse rate field picks four switch frequencies
// - new rate applies after current period ends
// - lockable bit 2 selects thermal cutoff level
// - lockable 2-bit field sets regulator current limit
// - soft reset keeps locked thermal/current settings
// - thermal register power-on 01, kept otherwise
// - pulse rate cleared power-on/soft, kept restart
// - scratch bytes cleared only at power-on
// - scratch written only in normal mode
// - two scratch bytes form one word
// - bit 7 enables oscillator calibration mode
// - only trim value 11 unlocks calibration/options
// - calibration locks to transmit data activity
// - mask bit 4 gates timeout interrupt
// - timeout flag updates only in wake mode
// - selective wake enabled only while valid set
// - valid cleared on wake, reset, config change
// - restart clears low nibble; soft clears all
// - quanta per bit, reset a0, kept restart
// - quantum length follows clock select field
// - reserved bits read as zero
// - lock commits at chip select rise, until power-up
`include "spw_map.vh"

module spw_config_regs #(
    parameter SYS_CLK_HZ = `SPW_SYS_CLK_HZ,
    parameter CAL_W = 16
) (
    input wire clk_sys,
    input wire resetn,
    input wire link_clk,
    input wire link_data_in,
    input wire chip_select_low_active_n,
    output wire link_data_out,
    output wire link_data_out_oe,
    input wire soft_reset,
    input wire restart,
    input wire normal_mode,
    input wire stop_mode,
    input wire config_lock_bit,
    input wire wake_event,
    input wire wake_config_changed,
    input wire selective_wake_can_mode,
    input wire bus_timeout_event,
    input wire bus_timeout_clear,
    input wire [1:0] quantum_clock_select,
    input wire transmit_data_input,
    output reg [1:0] switch_pulse_rate,
    output reg switch_period_start,
    output wire thermal_cutoff_level,
    output wire [1:0] regulator_current_limit_adjust,
    output wire [15:0] scratch_word,
    output wire oscillator_calibration_enable,
    output reg calibration_active,
    output reg [CAL_W-1:0] calibration_period,
    output reg calibration_done,
    output reg selective_wake_enable,
    output wire wake_option_write_enable,
    output reg bus_timeout_flag,
    output reg interrupt_output_n,
    output reg [10:0] bit_time_length,
    output reg config_locked
);

// ----------------------------------------------------------------------
// local helpers
// ----------------------------------------------------------------------
// full-width period figures, cut to the counter width on purpose below
localparam integer PER0_I = SYS_CLK_HZ / `SPW_RATE0_HZ;
localparam integer PER1_I = SYS_CLK_HZ / `SPW_RATE1_HZ;
localparam integer PER2_I = SYS_CLK_HZ / `SPW_RATE2_HZ;
localparam integer PER3_I = SYS_CLK_HZ / `SPW_RATE3_HZ;
// 24 bits cover the slowest rate at the default system clock
localparam [23:0] PER0 = PER0_I[23:0];
localparam [23:0] PER1 = PER1_I[23:0];
localparam [23:0] PER2 = PER2_I[23:0];
localparam [23:0] PER3 = PER3_I[23:0];

// period length in system cycles for one rate code
function [23:0] rate_period;
    input [1:0] code;
    begin
        case (code)
            2'h0: rate_period = PER0;
            2'h1: rate_period = PER1;
            2'h2: rate_period = PER2;
            default: rate_period = PER3;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------------
reg [1:0] sck_sync_r;
reg [1:0] sdi_sync_r;
reg [1:0] csn_sync_r;
reg [1:0] txd_sync_r;
reg sck_prev_r;
reg csn_prev_r;
reg txd_prev_r;

// two flops per outside input, then a history flop for edges
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        sck_sync_r <= 2'h0;
        sdi_sync_r <= 2'h0;
        csn_sync_r <= 2'h3;
        txd_sync_r <= 2'h3;
        sck_prev_r <= 1'b0;
        csn_prev_r <= 1'b1;
        txd_prev_r <= 1'b1;
    end else begin
        sck_sync_r <= {sck_sync_r[0], link_clk};
        sdi_sync_r <= {sdi_sync_r[0], link_data_in};
        csn_sync_r <= {csn_sync_r[0], chip_select_low_active_n};
        txd_sync_r <= {txd_sync_r[0], transmit_data_input};
        sck_prev_r <= sck_sync_r[1];
        csn_prev_r <= csn_sync_r[1];
        txd_prev_r <= txd_sync_r[1];
    end
end

wire sck_rise = sck_sync_r[1] & ~sck_prev_r;
wire sck_fall = ~sck_sync_r[1] & sck_prev_r;
wire cs_fall = ~csn_sync_r[1] & csn_prev_r;
wire cs_rise = csn_sync_r[1] & ~csn_prev_r;
wire cs_act = ~csn_sync_r[1];
wire txd_fall = ~txd_sync_r[1] & txd_prev_r;

// ----------------------------------------------------------------------
// register storage
// ----------------------------------------------------------------------
reg [1:0] pulse_rate_r;
reg [2:0] thermal_r;
reg [7:0] scratch_lo_r;
reg [7:0] scratch_hi_r;
reg [7:0] wake_ctrl_r;
reg [7:0] quanta_r;

// ----------------------------------------------------------------------
// link shifter: 16-bit frame, lsb first, addr[6:0], write flag, data
// ----------------------------------------------------------------------
reg [15:0] rx_sr_r;
reg [4:0] bit_cnt_r;
reg [7:0] tx_sr_r;
reg [7:0] rd_data;

// after eight bits the address of this frame sits in bits 14:8
wire [6:0] rd_addr = rx_sr_r[14:8];

// read multiplexer, reserved bits forced to zero
always @* begin
    if (rd_addr == `SPW_ADDR_PULSE_RATE)
        rd_data = {6'h00, pulse_rate_r};
    else if (rd_addr == `SPW_ADDR_THERMAL)
        rd_data = {5'h00, thermal_r};
    else if (rd_addr == `SPW_ADDR_SCRATCH_LO)
        rd_data = scratch_lo_r;
    else if (rd_addr == `SPW_ADDR_SCRATCH_HI)
        rd_data = scratch_hi_r;
    else if (rd_addr == `SPW_ADDR_WAKE_CTRL)
        rd_data = {wake_ctrl_r[7:4], 3'h0, wake_ctrl_r[0]};
    else if (rd_addr == `SPW_ADDR_QUANTA)
        rd_data = quanta_r;
    else
        rd_data = 8'h00;
end

// bit sampling on link rising edge, shifting out on falling edge
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        rx_sr_r <= 16'h0000;
        bit_cnt_r <= 5'h00;
        tx_sr_r <= 8'h00;
    end else if (cs_fall) begin
        bit_cnt_r <= 5'h00;
        tx_sr_r <= {5'h00, selective_wake_enable, config_locked,
                    bus_timeout_flag};
    end else if (cs_act) begin
        // count on past 16 so an over-long frame never commits
        if (sck_rise && bit_cnt_r != 5'h1f) begin
            rx_sr_r <= {sdi_sync_r[1], rx_sr_r[15:1]};
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        if (sck_fall) begin
            if (bit_cnt_r == `SPW_ADDR_BITS)
                tx_sr_r <= rd_data; // addressed byte for the second half
            else
                tx_sr_r <= {1'b0, tx_sr_r[7:1]};
        end
    end
end

assign link_data_out = tx_sr_r[0];
assign link_data_out_oe = cs_act;

// a whole frame with the write flag commits at chip select rise
wire wr_go = cs_rise && bit_cnt_r == `SPW_FRAME_BITS && rx_sr_r[7];
wire [6:0] wr_addr = rx_sr_r[6:0];
wire [7:0] wr_data = rx_sr_r[15:8];

// ----------------------------------------------------------------------
// configuration lock, held until power-up
// ----------------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
        config_locked <= 1'b0;
    else if (cs_rise && config_lock_bit)
        config_locked <= 1'b1;
end

// ----------------------------------------------------------------------
// pulse rate and thermal/current registers
// ----------------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        pulse_rate_r <= `SPW_RST_PULSE_RATE;
        thermal_r <= `SPW_RST_THERMAL;
    end else begin
        if (soft_reset)
            pulse_rate_r <= `SPW_RST_PULSE_RATE;
        else if (wr_go && wr_addr == `SPW_ADDR_PULSE_RATE)
            pulse_rate_r <= wr_data[1:0];
        // soft reset and restart keep the thermal bits
        if (wr_go && wr_addr == `SPW_ADDR_THERMAL && !config_locked)
            thermal_r <= wr_data[2:0];
    end
end

assign thermal_cutoff_level = thermal_r[`SPW_THERM_CUTOFF_BIT];
assign regulator_current_limit_adjust = thermal_r[1:0];

// ----------------------------------------------------------------------
// switch pulse period generator
// ----------------------------------------------------------------------
reg [23:0] period_cnt_r;
wire period_end = period_cnt_r >= rate_period(switch_pulse_rate) - 24'h1;

// new rate is taken only when the running period ends
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        period_cnt_r <= 24'h0;
        switch_pulse_rate <= `SPW_RST_PULSE_RATE;
        switch_period_start <= 1'b0;
    end else if (period_end) begin
        period_cnt_r <= 24'h0;
        switch_pulse_rate <= pulse_rate_r;
        switch_period_start <= 1'b1;
    end else begin
        period_cnt_r <= period_cnt_r + 24'h1;
        switch_period_start <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// scratch word
// ----------------------------------------------------------------------
wire scratch_wr = wr_go && normal_mode && !stop_mode;

// only power-on clears; soft reset, restart and fail-safe keep it
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        scratch_lo_r <= `SPW_RST_SCRATCH;
        scratch_hi_r <= `SPW_RST_SCRATCH;
    end else begin
        if (scratch_wr && wr_addr == `SPW_ADDR_SCRATCH_LO)
            scratch_lo_r <= wr_data;
        if (scratch_wr && wr_addr == `SPW_ADDR_SCRATCH_HI)
            scratch_hi_r <= wr_data;
    end
end

assign scratch_word = {scratch_hi_r, scratch_lo_r};

// ----------------------------------------------------------------------
// selective-wake control and bit quanta
// ----------------------------------------------------------------------
wire quanta_change = wr_go && wr_addr == `SPW_ADDR_QUANTA &&
                     wr_data != quanta_r;
wire cfg_clear = wake_event || wake_config_changed || quanta_change;

// restart clears the low nibble, soft reset everything
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        wake_ctrl_r <= `SPW_RST_WAKE_CTRL;
        quanta_r <= `SPW_RST_QUANTA;
    end else if (soft_reset) begin
        wake_ctrl_r <= `SPW_RST_WAKE_CTRL;
        quanta_r <= `SPW_RST_QUANTA;
    end else begin
        if (restart)
            wake_ctrl_r <= {wake_ctrl_r[7:4], 4'h0};
        else if (wr_go && wr_addr == `SPW_ADDR_WAKE_CTRL)
            wake_ctrl_r <= {wr_data[7:4], 3'h0,
                            wr_data[`SPW_WC_VALID_BIT]};
        else if (cfg_clear)
            wake_ctrl_r[`SPW_WC_VALID_BIT] <= 1'b0;
        if (wr_go && wr_addr == `SPW_ADDR_QUANTA)
            quanta_r <= wr_data;
    end
end

wire trim_unlocked =
    wake_ctrl_r[`SPW_WC_TRIM_HI:`SPW_WC_TRIM_LO] == `SPW_TRIM_UNLOCK;
assign oscillator_calibration_enable =
    wake_ctrl_r[`SPW_WC_CAL_BIT];
assign wake_option_write_enable = trim_unlocked;

// ----------------------------------------------------------------------
// oscillator calibration against transmit data edges
// ----------------------------------------------------------------------
reg [CAL_W-1:0] cal_cnt_r;
reg cal_armed_r;

// measures system cycles between falling edges of transmit data
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        calibration_active <= 1'b0;
        cal_cnt_r <= {CAL_W{1'b0}};
        cal_armed_r <= 1'b0;
        calibration_period <= {CAL_W{1'b0}};
        calibration_done <= 1'b0;
    end else begin
        calibration_active <= oscillator_calibration_enable &&
                              trim_unlocked;
        calibration_done <= 1'b0;
        if (!calibration_active) begin
            cal_armed_r <= 1'b0;
            cal_cnt_r <= {CAL_W{1'b0}};
        end else if (txd_fall) begin
            // start at one so the figure spans edge to edge
            cal_cnt_r <= {{(CAL_W-1){1'b0}}, 1'b1};
            cal_armed_r <= 1'b1;
            if (cal_armed_r) begin
                calibration_period <= cal_cnt_r;
                calibration_done <= 1'b1;
            end
        end else if (cal_cnt_r != {CAL_W{1'b1}}) begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
        end
    end
end

// ----------------------------------------------------------------------
// wake enable, timeout flag and interrupt
// ----------------------------------------------------------------------
// the set of a timeout wins over a clear in the same cycle
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        selective_wake_enable <= 1'b0;
        bus_timeout_flag <= 1'b0;
        interrupt_output_n <= 1'b1;
        bit_time_length <= 11'h000;
    end else begin
        selective_wake_enable <= wake_ctrl_r[`SPW_WC_VALID_BIT];
        if (bus_timeout_event && selective_wake_can_mode)
            bus_timeout_flag <= 1'b1;
        else if (bus_timeout_clear && selective_wake_can_mode)
            bus_timeout_flag <= 1'b0;
        interrupt_output_n <= ~(bus_timeout_event &&
                                selective_wake_can_mode &&
                                wake_ctrl_r[`SPW_WC_MASK_BIT]);
        bit_time_length <= {3'h0, quanta_r} <<
                           quantum_clock_select;
    end
end

endmodule // spw_config_regs

//--- testbench/spw_host_model.sv
// host-side link master that drives 16-bit register frames
`timescale 1ns/10ps
module spw_host_model (
    output logic link_clk,
    output logic link_data_in,
    output logic chip_select_low_active_n,
    input wire logic link_data_out
);
    // ------------------------------------------------------------
    // idle state and frame task
    // ------------------------------------------------------------
    // clock parked low and select high outside frames
    initial begin
        link_clk = 1'b0;
        link_data_in = 1'b0;
        chip_select_low_active_n = 1'b1;
    end
    // lsb first: address, write flag, data; rd is the second byte
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rd);
        logic [15:0] rx;
        chip_select_low_active_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            link_data_in = tx[i];
            #80 link_clk = 1'b1;
            rx[i] = link_data_out;
            #80 link_clk = 1'b0;
        end
        #80 chip_select_low_active_n = 1'b1;
        link_data_in = ~link_data_in; // released line shows no stale bit
        #120;
        rd = rx[15:8];
    endtask
endmodule // spw_host_model

//--- testbench/spw_config_regs_checker.sv
// concurrent checks on the register block's ports
`timescale 1ns/10ps
module spw_cfg_checker (
    input wire clk_sys,
    input wire resetn,
    input wire soft_reset,
    input wire restart,
    input wire normal_mode,
    input wire stop_mode,
    input wire wake_event,
    input wire selective_wake_can_mode,
    input wire bus_timeout_event,
    input wire [1:0] switch_pulse_rate,
    input wire switch_period_start,
    input wire thermal_cutoff_level,
    input wire [1:0] regulator_current_limit_adjust,
    input wire [15:0] scratch_word,
    input wire oscillator_calibration_enable,
    input wire calibration_active,
    input wire wake_option_write_enable,
    input wire selective_wake_enable,
    input wire bus_timeout_flag,
    input wire interrupt_output_n,
    input wire config_locked
);
    // ------------------------------------------------------------
    // assertions, all in the system clock domain
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    AST_IRQ_ONE: assert property (
        !interrupt_output_n |=> interrupt_output_n)
        else $error("interrupt low longer than one cycle");
    AST_IRQ_CAUSE: assert property (
        $fell(interrupt_output_n) |->
        $past(bus_timeout_event) || $past(bus_timeout_event, 2))
        else $error("interrupt without timeout event");
    AST_FLAG_MODE: assert property (
        $rose(bus_timeout_flag) |->
        $past(selective_wake_can_mode) && $past(bus_timeout_event))
        else $error("timeout flag set outside wake mode");
    AST_CAL_TRIM: assert property (
        calibration_active |-> $past(oscillator_calibration_enable)
        && $past(wake_option_write_enable))
        else $error("calibration active while locked");
    AST_VALID_CLEAR: assert property (
        (wake_event || soft_reset || restart) |->
        ##[1:3] !selective_wake_enable)
        else $error("wake enable not cleared");
    AST_LOCK_HOLD: assert property (
        config_locked |=> config_locked)
        else $error("lock released before power-up");
    AST_THERM_LOCK: assert property (
        config_locked |=>
        $stable({thermal_cutoff_level, regulator_current_limit_adjust}))
        else $error("locked thermal settings changed");
    AST_SCRATCH_MODE: assert property (
        $changed(scratch_word) |->
        $past(normal_mode) && !$past(stop_mode))
        else $error("scratch changed outside normal mode");
    AST_RATE_PERIOD: assert property (
        $changed(switch_pulse_rate) && !$past(soft_reset)
        && !$past(soft_reset, 2) |->
        switch_period_start || $past(switch_period_start))
        else $error("pulse rate applied mid-period");
endmodule // spw_cfg_checker

bind spw_config_regs spw_cfg_checker u_chk (.*);

//--- testbench/spw_config_regs_tb_top.sv
// self-checking bench for the pulse, thermal and wake registers
`timescale 1ns/10ps
`include "spw_map.vh"
module spw_config_regs_tb_top;
    localparam logic [6:0] a_pr = `SPW_ADDR_PULSE_RATE;
    localparam logic [6:0] a_th = `SPW_ADDR_THERMAL;
    localparam logic [6:0] a_sl = `SPW_ADDR_SCRATCH_LO;
    localparam logic [6:0] a_sh = `SPW_ADDR_SCRATCH_HI;
    localparam logic [6:0] a_wc = `SPW_ADDR_WAKE_CTRL;
    localparam logic [6:0] a_q = `SPW_ADDR_QUANTA;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic soft_reset = 1'b0, restart = 1'b0, wake_event = 1'b0;
    logic normal_mode = 1'b1, stop_mode = 1'b0, config_lock_bit = 1'b0;
    logic wake_config_changed = 1'b0, selective_wake_can_mode = 1'b0;
    logic bus_timeout_event = 1'b0, bus_timeout_clear = 1'b0;
    logic transmit_data_input = 1'b1;
    logic [1:0] quantum_clock_select = 2'h0;
    logic link_clk, link_data_in, chip_select_low_active_n;
    logic link_data_out, link_data_out_oe, switch_period_start;
    logic [1:0] switch_pulse_rate, regulator_current_limit_adjust;
    logic thermal_cutoff_level, oscillator_calibration_enable;
    logic calibration_active, calibration_done, selective_wake_enable;
    logic wake_option_write_enable, bus_timeout_flag;
    logic interrupt_output_n, config_locked;
    logic [15:0] scratch_word, calibration_period;
    logic [10:0] bit_time_length;
    int errors = 0, total_checks = 0, cycles = 0;
    int cal_pulses = 0;

    spw_config_regs #(.SYS_CLK_HZ(40000)) dut (.*);
    spw_host_model host (.*);

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    // 100 MHz clock and a cap on run length
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            give_verdict();
        end
    end
    // count one-cycle calibration results at the settled edge
    always @(negedge clk_sys)
        if (calibration_done === 1'b1)
            cal_pulses++;
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({d, 1'b1, a}, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.xfer({8'h00, 1'b0, a}, r);
        chk(r, e);
    endtask
    task automatic pl(ref logic s);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
    endtask
    // cycles from one period start to the next
    task automatic gap(output int n);
        n = 0;
        while (switch_period_start !== 1'b1) @(negedge clk_sys);
        do begin
            @(negedge clk_sys);
            n++;
        end while (switch_period_start !== 1'b1 && n < 900);
    endtask
    // timeout pulse; seen reports an interrupt within four cycles
    task automatic tmo(output logic seen);
        seen = 1'b0;
        pl(bus_timeout_clear);
        bus_timeout_event = 1'b1;
        repeat (4) begin
            @(negedge clk_sys);
            bus_timeout_event = 1'b0;
            if (interrupt_output_n === 1'b0) seen = 1'b1;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(a_pr, 8'h00);
        rd(a_th, 8'h01);
        rd(a_sl, 8'h00);
        rd(a_sh, 8'h00);
        rd(a_wc, 8'h00);
        rd(a_q, 8'ha0);
        chk(link_data_out_oe, 1'b0);
        fork
            rd(7'h30, 8'h00);
            begin
                repeat (8) @(negedge clk_sys);
                chk(link_data_out_oe, 1'b1);
            end
        join
    endtask
    task automatic t_pulse;
        int n, per[4];
        per = '{40000 / `SPW_RATE0_HZ, 40000 / `SPW_RATE1_HZ,
            40000 / `SPW_RATE2_HZ, 40000 / `SPW_RATE3_HZ};
        for (int c = 3; c >= 0; c--) begin
            wr(a_pr, 8'hfc | c[7:0]);
            rd(a_pr, c[7:0]);
            gap(n);
            gap(n);
            chk(n, per[c]);
            chk(switch_pulse_rate, c[1:0]);
        end
        wr(a_pr, 8'h02);
        pl(restart);
        rd(a_pr, 8'h02);
        pl(soft_reset);
        rd(a_pr, 8'h00);
    endtask
    task automatic t_scratch;
        wr(a_sl, 8'h5a);
        wr(a_sh, 8'hc3);
        chk(scratch_word, 16'hc35a);
        normal_mode = 1'b0;
        stop_mode = 1'b1;
        wr(a_sl, 8'h00);
        rd(a_sl, 8'h5a);
        normal_mode = 1'b1;
        stop_mode = 1'b0;
        pl(soft_reset);
        pl(restart);
        rd(a_sh, 8'hc3);
        chk(scratch_word, 16'hc35a);
    endtask
    task automatic t_wake;
        logic s;
        wr(a_wc, 8'hff);
        rd(a_wc, 8'hf1);
        for (int t = 0; t < 4; t++) begin
            wr(a_wc, {1'b1, t[1:0], 5'h00});
            chk({oscillator_calibration_enable, wake_option_write_enable,
                calibration_active}, {1'b1, {2{t == 3}}});
        end
        // falling edges on the transmit input every 20 cycles
        repeat (4) begin
            transmit_data_input = 1'b0;
            repeat (10) @(negedge clk_sys);
            transmit_data_input = 1'b1;
            repeat (10) @(negedge clk_sys);
        end
        chk(calibration_period, 16'h0014);
        chk(cal_pulses, 3);
        selective_wake_can_mode = 1'b1;
        wr(a_wc, 8'h01);
        chk(selective_wake_enable, 1'b1);
        tmo(s);
        chk({s, bus_timeout_flag}, 2'h1);
        wr(a_wc, 8'h11);
        tmo(s);
        chk({s, bus_timeout_flag}, 2'h3);
        pl(bus_timeout_clear);
        selective_wake_can_mode = 1'b0;
        tmo(s);
        chk({s, bus_timeout_flag}, 2'h0);
        pl(wake_event);
        rd(a_wc, 8'h10);
        chk(selective_wake_enable, 1'b0);
        wr(a_wc, 8'h11);
        pl(wake_config_changed);
        rd(a_wc, 8'h10);
        wr(a_wc, 8'h11);
        wr(a_q, 8'h0c);
        rd(a_wc, 8'h10);
        wr(a_wc, 8'hf1);
        pl(restart);
        rd(a_wc, 8'hf0);
        rd(a_q, 8'h0c);
        for (int q = 0; q < 4; q++) begin
            quantum_clock_select = q[1:0];
            repeat (3) @(negedge clk_sys);
            chk(bit_time_length, 11'h00c << q);
        end
        pl(soft_reset);
        rd(a_wc, 8'h00);
        rd(a_q, 8'ha0);
    endtask
    task automatic t_lock;
        wr(a_th, 8'h03);
        rd(a_th, 8'h03);
        wr(a_th, 8'hfe);
        rd(a_th, 8'h06);
        chk({thermal_cutoff_level, regulator_current_limit_adjust},
            3'h6);
        pl(soft_reset);
        rd(a_th, 8'h06);
        config_lock_bit = 1'b1;
        rd(a_th, 8'h06);
        chk(config_locked, 1'b1);
        config_lock_bit = 1'b0;
        wr(a_th, 8'h01);
        pl(soft_reset);
        pl(restart);
        rd(a_th, 8'h06);
        chk(config_locked, 1'b1);
    endtask

    // reset for 16 cycles, then every scenario in turn
    initial begin
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_pulse();
        t_scratch();
        t_wake();
        t_lock();
        give_verdict();
    end
endmodule // spw_config_regs_tb_top
